// >>> hdl/sat_pkg.sv
// Package: constants, types and register map of the scan/arm sequencer
package sat_pkg;

   // --------------------------------------------------------------
   // Register map, byte addresses on the APB bus
   // --------------------------------------------------------------
   localparam logic [7:0] SAT_ADDR_CTRL = 8'h00;
   localparam logic [7:0] SAT_ADDR_SRC = 8'h04;
   localparam logic [7:0] SAT_ADDR_SCNT = 8'h08;
   localparam logic [7:0] SAT_ADDR_ACNT = 8'h0C;
   localparam logic [7:0] SAT_ADDR_INTV = 8'h10;
   localparam logic [7:0] SAT_ADDR_DLY = 8'h14;
   localparam logic [7:0] SAT_ADDR_STAT = 8'h18;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int SAT_CTRL_GO = 0;
   localparam int SAT_CTRL_ABORT = 1;
   localparam int SAT_CTRL_SBYP = 2;
   localparam int SAT_CTRL_ABYP = 3;
   localparam int SAT_CTRL_SINF = 4;
   localparam int SAT_CTRL_AINF = 5;
   localparam int SAT_SRC_SCAN = 0;
   localparam int SAT_SRC_ARM = 4;
   localparam int SAT_SRC_IN = 8;
   localparam int SAT_SRC_OUT = 12;
   localparam int SAT_STAT_ERR = 8;
   localparam int SAT_STAT_SDONE = 12;

   // --------------------------------------------------------------
   // Limits and values after reset
   // --------------------------------------------------------------
   localparam int SAT_LINES = 6;
   localparam logic [16:0] SAT_CNT_MAX = 17'h1_869F;
   localparam logic [29:0] SAT_MS_MAX = 30'h3B9A_C9FF;
   localparam logic [16:0] SAT_CNT_RST = 17'h0_0001;
   localparam logic [29:0] SAT_INTV_RST = 30'h0000_03E8;
   localparam logic [29:0] SAT_DLY_RST = 30'h0000_0000;
   localparam logic [2:0] SAT_IN_RST = 3'h1;
   localparam logic [2:0] SAT_OUT_RST = 3'h2;

   // --------------------------------------------------------------
   // Timing: 1 ms tick from the 50 MHz bus clock
   // --------------------------------------------------------------
   localparam int SAT_CLK_HZ = 50_000_000;
   localparam int SAT_TICK_MS = 1;
   localparam int SAT_TICK_CYC = SAT_CLK_HZ / 1000 * SAT_TICK_MS;

   // --------------------------------------------------------------
   // Types
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      SAT_SRC_IMM = 3'h0,
      SAT_SRC_EXT = 3'h1,
      SAT_SRC_MAN = 3'h2,
      SAT_SRC_BUS = 3'h3,
      SAT_SRC_TLNK = 3'h4,
      SAT_SRC_TMR = 3'h5,
      SAT_SRC_HOLD = 3'h6
   } sat_src_type;

   typedef enum logic [4:0] {
      SAT_IDLE = 5'h01,
      SAT_ARM_WAIT = 5'h02,
      SAT_SCAN_WAIT = 5'h04,
      SAT_SCAN_DELAY = 5'h08,
      SAT_MEASURE = 5'h10
   } sat_state_type;

   typedef struct packed {
      sat_src_type scan_src;
      sat_src_type arm_src;
      logic [2:0] in_line;
      logic [2:0] out_line;
      logic scan_byp;
      logic arm_byp;
      logic scan_inf;
      logic arm_inf;
      logic [16:0] scan_cnt;
      logic [16:0] arm_cnt;
      logic [29:0] intv;
      logic [29:0] dly;
   } sat_cfg_type;

endpackage : sat_pkg

// >>> hdl/sat_sequencer.sv
// Module: scan and arm layer trigger sequencer with APB registers
// Overview of operation
// - Immediate scan source needs no event; only the scan delay precedes the measure layer.
// - External source: falling edge on external trigger input is the event.
// - Key press also counts for external, bus, trigger bus and timer.
// - Manual source advances only on a trigger key press.
// - Bus source advances on a bus trigger pulse.
// - Trigger bus source advances on a pulse on the chosen input line.
// - Six trigger bus lines; input and output chosen by number.
// - A setting with input line equal to output line is refused.
// - Interval from 1 ms to 999999.999 s in 1 ms steps.
// - Timer: next scan starts when interval since last start expires.
// - Expiry during a running scan waits until that scan finishes.
// - Timer: key press after a scan completes starts the next one.
// - Hold source: nothing advances until another source is chosen.
// - After the event, wait the scan delay, 0 to 999999.999 s.
// - Scan count 1 to 99999, one after reset.
// - Unbounded_repeat_setting scan count returns to the scan layer forever.
// - Scan bypass skips the event on the first scan pass.
// - Bypass off: event awaited on every pass including the first.
// - Immediate arm source passes straight into the scan layer.
// - External arm source waits for an external trigger pulse.
// - Arm layer keeps an arm count and an arm bypass.
// - Arm count 1 to 99999 or unbounded_repeat_setting.
// - Arm bypass skips the arm event on the first arm pass.
`timescale 1ns/100ps
module sat_sequencer #(
   parameter int TICK_CYC = sat_pkg::SAT_TICK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_front_panel_trigger_key_n,
   input wire logic front_panel_trigger_key_n,
   input wire logic [5:0] front_panel_trigger_key_bus_in_n,
   input wire logic bus_trigger,
   input wire logic meas_done,
   output logic meas_start,
   output logic [5:0] front_panel_trigger_key_bus_out_sel,
   output logic busy
);

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   typedef struct packed {
      sat_pkg::sat_cfg_type cfg;
      sat_pkg::sat_state_type st;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] stab;
      logic [15:0] div;
      logic [29:0] ms_cnt;
      logic [29:0] intv_cnt;
      logic expired;
      logic first_scan;
      logic first_arm;
      logic [16:0] scans;
      logic [16:0] arms;
      logic cfg_err;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic meas_start;
      logic [5:0] out_sel;
      logic busy;
   } sat_regs_type;

   sat_regs_type r;
   sat_regs_type next_r;
   logic [7:0] fall;
   logic tick;
   logic wr_en;
   logic abort_req;
   logic ext_ev;
   logic key_ev;
   logic tl_ev;
   logic scan_hit;
   logic arm_hit;

   // Event decode shared by the scan and the arm layer
   function automatic logic sat_event(sat_pkg::sat_src_type src, logic ext,
                                      logic key, logic bus, logic tl,
                                      logic tmr);
      logic hit;
      hit = 1'b0;
      case (src)
         sat_pkg::SAT_SRC_IMM: hit = 1'b1;
         sat_pkg::SAT_SRC_EXT: hit = ext | key;
         sat_pkg::SAT_SRC_MAN: hit = key;
         sat_pkg::SAT_SRC_BUS: hit = bus | key;
         sat_pkg::SAT_SRC_TLNK: hit = tl | key;
         sat_pkg::SAT_SRC_TMR: hit = tmr | key;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : sat_event

   // Range check for counts 1..99999
   function automatic logic sat_cnt_ok(logic [31:0] v);
      return (v[31:17] == 15'h0000) && (v[16:0] != 17'h0_0000) &&
             (v[16:0] <= sat_pkg::SAT_CNT_MAX);
   endfunction : sat_cnt_ok

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      fall = 8'h00;
      tick = 1'b0;
      // Three-stage synchroniser; change once stages two and three agree
      next_r.s1 = {front_panel_trigger_key_n, ext_front_panel_trigger_key_n, front_panel_trigger_key_bus_in_n};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < 8; i++)
      begin
         if (r.s2[i] == r.s3[i] && r.s3[i] != r.stab[i])
         begin
            next_r.stab[i] = r.s3[i];
            fall[i] = ~r.s3[i];
         end
      end
      key_ev = fall[7];
      ext_ev = fall[6];
      tl_ev = 1'b0;
      // Selected input line, numbered 1..6
      for (int i = 0; i < sat_pkg::SAT_LINES; i++)
      begin
         if (r.cfg.in_line == 3'(i + 1) && fall[i])
         begin
            tl_ev = 1'b1;
         end
      end
      // 1 ms tick divider
      if (r.div == 16'(TICK_CYC - 1))
      begin
         next_r.div = 16'h0000;
         tick = 1'b1;
      end
      else
      begin
         next_r.div = r.div + 16'h0001;
      end
      // APB slave: answer one cycle into the access phase
      next_r.pready = psel & penable & ~r.pready;
      next_r.pslverr = 1'b0;
      next_r.meas_start = 1'b0;
      wr_en = psel & penable & r.pready & pwrite;
      abort_req = wr_en && paddr == sat_pkg::SAT_ADDR_CTRL &&
                  pwdata[sat_pkg::SAT_CTRL_ABORT];
      if (psel & penable & ~r.pready)
      begin
         case (paddr)
            sat_pkg::SAT_ADDR_CTRL: next_r.prdata = {26'h000_0000,
               r.cfg.arm_inf, r.cfg.scan_inf, r.cfg.arm_byp,
               r.cfg.scan_byp, 2'h0};
            sat_pkg::SAT_ADDR_SRC: next_r.prdata = {17'h0_0000,
               r.cfg.out_line, 1'b0, r.cfg.in_line, 1'b0, r.cfg.arm_src,
               1'b0, r.cfg.scan_src};
            sat_pkg::SAT_ADDR_SCNT: next_r.prdata = {15'h0000, r.cfg.scan_cnt};
            sat_pkg::SAT_ADDR_ACNT: next_r.prdata = {15'h0000, r.cfg.arm_cnt};
            sat_pkg::SAT_ADDR_INTV: next_r.prdata = {2'h0, r.cfg.intv};
            sat_pkg::SAT_ADDR_DLY: next_r.prdata = {2'h0, r.cfg.dly};
            sat_pkg::SAT_ADDR_STAT: next_r.prdata = {3'h0, r.scans,
               3'h0, r.cfg_err, 3'h0, r.st};
            default:
            begin
               next_r.prdata = 32'h0000_0000;
               next_r.pslverr = 1'b1; // Unmapped address
            end
         endcase
      end
      // Register writes; a refused value keeps the old one and flags it
      if (wr_en)
      begin
         case (paddr)
            sat_pkg::SAT_ADDR_CTRL:
            begin
               next_r.cfg.scan_byp = pwdata[sat_pkg::SAT_CTRL_SBYP];
               next_r.cfg.arm_byp = pwdata[sat_pkg::SAT_CTRL_ABYP];
               next_r.cfg.scan_inf = pwdata[sat_pkg::SAT_CTRL_SINF];
               next_r.cfg.arm_inf = pwdata[sat_pkg::SAT_CTRL_AINF];
            end
            sat_pkg::SAT_ADDR_SRC:
            begin
               if (pwdata[10:8] != pwdata[14:12] &&
                   pwdata[10:8] >= 3'h1 && pwdata[10:8] <= 3'h6 &&
                   pwdata[14:12] >= 3'h1 && pwdata[14:12] <= 3'h6 &&
                   pwdata[2:0] <= 3'h6 && pwdata[6:4] <= 3'h6)
               begin
                  // Source change takes effect at once
                  next_r.cfg.scan_src = sat_pkg::sat_src_type'(pwdata[2:0]);
                  next_r.cfg.arm_src = sat_pkg::sat_src_type'(pwdata[6:4]);
                  next_r.cfg.in_line = pwdata[10:8];
                  next_r.cfg.out_line = pwdata[14:12];
               end
               else
               begin
                  next_r.cfg_err = 1'b1;
               end
            end
            sat_pkg::SAT_ADDR_SCNT:
               if (sat_cnt_ok(pwdata)) next_r.cfg.scan_cnt = pwdata[16:0];
               else next_r.cfg_err = 1'b1;
            sat_pkg::SAT_ADDR_ACNT:
               if (sat_cnt_ok(pwdata)) next_r.cfg.arm_cnt = pwdata[16:0];
               else next_r.cfg_err = 1'b1;
            sat_pkg::SAT_ADDR_INTV:
               if (pwdata[31:30] == 2'h0 && pwdata[29:0] != 30'h0000_0000 &&
                   pwdata[29:0] <= sat_pkg::SAT_MS_MAX)
                  next_r.cfg.intv = pwdata[29:0];
               else next_r.cfg_err = 1'b1;
            sat_pkg::SAT_ADDR_DLY:
               if (pwdata[31:30] == 2'h0 && pwdata[29:0] <= sat_pkg::SAT_MS_MAX)
                  next_r.cfg.dly = pwdata[29:0];
               else next_r.cfg_err = 1'b1;
            sat_pkg::SAT_ADDR_STAT:
               if (pwdata[sat_pkg::SAT_STAT_ERR]) next_r.cfg_err = 1'b0;
            default: next_r.cfg_err = r.cfg_err;
         endcase
      end
      // Output line select as one-hot
      for (int i = 0; i < sat_pkg::SAT_LINES; i++)
      begin
         next_r.out_sel[i] = (next_r.cfg.out_line == 3'(i + 1));
      end
      // Interval timer, measured from the last scan start
      if (tick && !r.expired)
      begin
         if (r.intv_cnt + 30'h0000_0001 >= r.cfg.intv)
         begin
            next_r.expired = 1'b1;
         end
         else
         begin
            next_r.intv_cnt = r.intv_cnt + 30'h0000_0001;
         end
      end
      scan_hit = sat_event(r.cfg.scan_src, ext_ev, key_ev, bus_trigger,
                           tl_ev, r.expired);
      arm_hit = sat_event(r.cfg.arm_src, ext_ev, key_ev, bus_trigger, tl_ev,
                          1'b0);
      // Sequencer
      case (r.st)
         sat_pkg::SAT_IDLE:
            if (wr_en && paddr == sat_pkg::SAT_ADDR_CTRL &&
                pwdata[sat_pkg::SAT_CTRL_GO] && !abort_req)
            begin
               next_r.st = sat_pkg::SAT_ARM_WAIT;
               next_r.arms = 17'h0_0000;
               next_r.first_arm = 1'b1;
            end
         sat_pkg::SAT_ARM_WAIT:
            if ((r.first_arm && r.cfg.arm_byp) || arm_hit)
            begin
               next_r.st = sat_pkg::SAT_SCAN_WAIT;
               next_r.first_arm = 1'b0;
               next_r.first_scan = 1'b1;
               next_r.scans = 17'h0_0000;
               next_r.expired = 1'b1; // First timed scan starts at once
            end
         sat_pkg::SAT_SCAN_WAIT:
            // Expiry only counts here, after the scan finished
            if ((r.first_scan && r.cfg.scan_byp) || scan_hit)
            begin
               next_r.st = sat_pkg::SAT_SCAN_DELAY;
               next_r.first_scan = 1'b0;
               next_r.ms_cnt = 30'h0000_0000;
            end
         sat_pkg::SAT_SCAN_DELAY:
            if (r.ms_cnt >= r.cfg.dly)
            begin
               next_r.st = sat_pkg::SAT_MEASURE;
               next_r.meas_start = 1'b1;
               next_r.intv_cnt = 30'h0000_0000;
               next_r.expired = 1'b0;
            end
            else if (tick)
            begin
               next_r.ms_cnt = r.ms_cnt + 30'h0000_0001;
            end
         sat_pkg::SAT_MEASURE:
            if (meas_done)
            begin
               next_r.scans = r.scans + 17'h0_0001;
               if (r.cfg.scan_inf || r.scans + 17'h0_0001 < r.cfg.scan_cnt)
               begin
                  next_r.st = sat_pkg::SAT_SCAN_WAIT;
               end
               else if (r.cfg.arm_inf ||
                        r.arms + 17'h0_0001 < r.cfg.arm_cnt)
               begin
                  next_r.arms = r.arms + 17'h0_0001;
                  next_r.st = sat_pkg::SAT_ARM_WAIT;
               end
               else
               begin
                  next_r.st = sat_pkg::SAT_IDLE;
               end
            end
         default: next_r.st = sat_pkg::SAT_IDLE;
      endcase
      if (abort_req)
      begin
         next_r.st = sat_pkg::SAT_IDLE;
      end
      // Busy flag kept in a flip-flop, follows the next state
      next_r.busy = next_r.st != sat_pkg::SAT_IDLE;
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.cfg.scan_src <= sat_pkg::SAT_SRC_IMM;
         r.cfg.arm_src <= sat_pkg::SAT_SRC_IMM;
         r.cfg.in_line <= sat_pkg::SAT_IN_RST;
         r.cfg.out_line <= sat_pkg::SAT_OUT_RST;
         r.cfg.scan_cnt <= sat_pkg::SAT_CNT_RST;
         r.cfg.arm_cnt <= sat_pkg::SAT_CNT_RST;
         r.cfg.intv <= sat_pkg::SAT_INTV_RST;
         r.cfg.dly <= sat_pkg::SAT_DLY_RST;
         r.st <= sat_pkg::SAT_IDLE;
         r.s1 <= 8'hFF;
         r.s2 <= 8'hFF;
         r.s3 <= 8'hFF;
         r.stab <= 8'hFF;
         r.out_sel <= 6'h02;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs straight from the state flip-flops
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign meas_start = r.meas_start;
   assign front_panel_trigger_key_bus_out_sel = r.out_sel;
   assign busy = r.busy;

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic in_wait;
   assign in_wait = r.st == sat_pkg::SAT_SCAN_WAIT && !abort_req &&
                    !(r.first_scan && r.cfg.scan_byp);

   AST_IMM_ADVANCE: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_IMM
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("immediate scan source did not advance");
   AST_EXT_ADVANCE: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_EXT && ext_ev
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("external trigger did not advance scan");
   AST_KEY_ALSO: assert property (
      in_wait && key_ev && r.cfg.scan_src inside {sat_pkg::SAT_SRC_EXT,
      sat_pkg::SAT_SRC_BUS, sat_pkg::SAT_SRC_TLNK, sat_pkg::SAT_SRC_TMR}
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("trigger key ignored");
   AST_MANUAL_ONLY_KEY: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_MAN && !key_ev
      |=> r.st == sat_pkg::SAT_SCAN_WAIT)
      else $error("manual source advanced without key");
   AST_BUS_ADVANCE: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_BUS && bus_trigger
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("bus trigger did not advance scan");
   AST_TLINK_ADVANCE: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_TLNK && tl_ev
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("trigger bus pulse did not advance scan");
   AST_LINES_DIFFER: assert property (
      r.cfg.in_line != r.cfg.out_line && $onehot(r.out_sel))
      else $error("trigger bus input and output share a line");
   AST_TIMER_RESTART: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_TMR && r.expired
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("expired interval did not start next scan");
   AST_HOLD_OFF: assert property (
      r.st == sat_pkg::SAT_MEASURE && !meas_done && !abort_req
      |=> r.st == sat_pkg::SAT_MEASURE && !r.meas_start)
      else $error("scan restarted before previous one finished");
   AST_HOLD_STAYS: assert property (
      in_wait && r.cfg.scan_src == sat_pkg::SAT_SRC_HOLD
      |=> r.st == sat_pkg::SAT_SCAN_WAIT)
      else $error("hold source let scan advance");
   AST_ZERO_DELAY: assert property (
      r.st == sat_pkg::SAT_SCAN_DELAY && r.cfg.dly == 30'h0000_0000 &&
      !abort_req |=> r.meas_start ##1 !r.meas_start)
      else $error("zero delay did not start measure at once");
   AST_BYPASS_FIRST: assert property (
      r.st == sat_pkg::SAT_SCAN_WAIT && $past(r.st) == sat_pkg::SAT_ARM_WAIT
      && r.cfg.scan_byp && !abort_req
      |=> r.st == sat_pkg::SAT_SCAN_DELAY)
      else $error("scan bypass did not skip first event");
   AST_ARM_IMM: assert property (
      r.st == sat_pkg::SAT_ARM_WAIT && !abort_req &&
      r.cfg.arm_src == sat_pkg::SAT_SRC_IMM
      |=> r.st == sat_pkg::SAT_SCAN_WAIT)
      else $error("immediate arm source did not pass to scan");
   AST_BACK_TO_ARM: assert property (
      r.st == sat_pkg::SAT_MEASURE && meas_done && !abort_req &&
      !r.cfg.scan_inf && r.scans + 17'h0_0001 == r.cfg.scan_cnt &&
      !r.cfg.arm_inf && r.arms + 17'h0_0001 < r.cfg.arm_cnt
      |=> r.st == sat_pkg::SAT_ARM_WAIT)
      else $error("spent scan count did not return to arm layer");

   COV_RUN_DONE: cover property (r.st == sat_pkg::SAT_MEASURE && meas_done
      ##1 r.st == sat_pkg::SAT_IDLE);
   COV_TIMER: cover property (r.expired && r.st == sat_pkg::SAT_MEASURE);
   COV_TLINK: cover property (tl_ev && r.st == sat_pkg::SAT_SCAN_WAIT);
   COV_REARM: cover property (r.st == sat_pkg::SAT_MEASURE
      ##1 r.st == sat_pkg::SAT_ARM_WAIT);

endmodule : sat_sequencer

// >>> bench/sat_meas_model.sv
// Measure layer stand-in that answers each scan start with a done pulse
`timescale 1ns/100ps
module sat_meas_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic meas_start,
   input wire logic [7:0] lat,
   output logic meas_done
);
   logic [8:0] cnt;
   // Count lat cycles from each start, then pulse done once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 9'h000;
         meas_done <= 1'b0;
      end
      else
      begin
         meas_done <= (cnt == 9'h001);
         if (meas_start)
            cnt <= {1'b0, lat} + 9'h001;
         else if (cnt != 9'h000)
            cnt <= cnt - 9'h001;
      end
   end
endmodule : sat_meas_model

// >>> bench/tb.sv
// Self-checking testbench of the scan and arm trigger sequencer
`timescale 1ns/100ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
   logic ext_n, key_n, bus_trigger, meas_done, meas_start;
   logic [7:0] paddr, lat;
   logic [31:0] pwdata, prdata;
   logic [5:0] tin_n, tout;
   logic [32:0] expq[$];
   int failures = 0, num_checks = 0, starts = 0, b;
   int evt[6] = '{0, 1, 2, 3, 4, 0};
   sat_sequencer #(.TICK_CYC(10)) sat_sequencer_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_front_panel_trigger_key_n(ext_n),
      .front_panel_trigger_key_n(key_n), .front_panel_trigger_key_bus_in_n(tin_n),
      .bus_trigger(bus_trigger), .meas_done(meas_done),
      .meas_start(meas_start), .front_panel_trigger_key_bus_out_sel(tout), .busy(busy));
   sat_meas_model sat_meas_model_i (.pclk(pclk), .presetn(presetn),
      .meas_start(meas_start), .lat(lat), .meas_done(meas_done));
   // Clock of 20 ns
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Count scan starts and compare each read answer with the oldest note
   always @(posedge pclk)
   begin
      if (meas_start === 1'b1)
         starts <= starts + 1;
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk("read", expq.pop_front(), {pslverr, prdata});
   end
   task automatic chk(input string what, input logic [32:0] e,
      input logic [32:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic guard(input logic ok);
      if (!ok)
      begin
         failures++;
         tally_and_finish();
      end
   endtask : guard
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && n++ < 20);
      guard(pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle cycle so the next setup never reassigns psel at this edge
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd
   task automatic wait_n(input int n);
      int k;
      k = 0;
      while (starts < n && k++ < 400)
         @(posedge pclk);
      chk("starts", 33'(n), 33'(starts));
      guard(starts >= n);
   endtask : wait_n
   // Drive one event: ext pin, key, bus trigger, line 1, or leave hold
   task automatic fire(input int ev);
      case (ev)
         1: ext_n <= 1'b0;
         2: key_n <= 1'b0;
         3: bus_trigger <= 1'b1;
         4: tin_n <= 6'h3E;
         5: apb(1'b1, sat_pkg::SAT_ADDR_SRC, 32'h0000_2100);
         default: ;
      endcase
      @(posedge pclk);
      bus_trigger <= 1'b0;
      repeat (100) @(posedge pclk);
      ext_n <= 1'b1;
      key_n <= 1'b1;
      tin_n <= 6'h3F;
   endtask : fire
   task automatic run(input logic [31:0] src, input logic [31:0] ctrl,
      input int ev, input int early);
      b = starts;
      lat <= 8'($urandom_range(8, 1));
      apb(1'b1, sat_pkg::SAT_ADDR_SRC, src);
      apb(1'b1, sat_pkg::SAT_ADDR_CTRL, ctrl);
      repeat (30) @(posedge pclk);
      chk("early", 33'(b + early), 33'(starts));
      fire(ev);
      wait_n(b + 1);
      repeat (20) @(posedge pclk);
   endtask : run
   // Main sequence
   initial
   begin
      void'($urandom(32'h0870));
      {psel, penable, pwrite, paddr, pwdata, bus_trigger} = '0;
      {ext_n, key_n, tin_n, lat} = {8'hFF, 8'h04};
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(sat_pkg::SAT_ADDR_SRC, 33'h0_0000_2100);
      rd(sat_pkg::SAT_ADDR_SCNT, 33'h0_0000_0001);
      rd(sat_pkg::SAT_ADDR_INTV, 33'h0_0000_03E8);
      rd(8'h1C, 33'h1_0000_0000);
      chk("out_sel", 33'h0_0000_0002, {27'h0, tout});
      for (int o = 1; o <= 6; o++)
      begin
         apb(1'b1, sat_pkg::SAT_ADDR_SRC, {17'h0_0000, 3'(o), 1'b0,
            3'((o + $urandom_range(4, 0)) % 6 + 1), 8'h00});
         repeat (2) @(posedge pclk);
         chk("out_sel", 33'(6'h01 << (o - 1)), {27'h0, tout});
      end
      apb(1'b1, sat_pkg::SAT_ADDR_SRC, 32'h0000_2100);
      apb(1'b1, sat_pkg::SAT_ADDR_SRC, 32'h0000_3300);
      rd(sat_pkg::SAT_ADDR_SRC, 33'h0_0000_2100);
      rd(sat_pkg::SAT_ADDR_STAT, 33'h0_0000_0101);
      apb(1'b1, sat_pkg::SAT_ADDR_STAT, 32'h0000_0100);
      for (int k = 0; k < 2; k++)
         for (int s = 0; s < 6; s++)
            run(32'h0000_2100 | s, 32'h0000_0001,
               (k == 1 && evt[s] > 0) ? 2 : evt[s],
               evt[s] == 0);
      run(32'h0000_2106, 32'h0000_0001, 5, 0);
      run(32'h0000_2110, 32'h0000_0001, 1, 0);
      run(32'h0000_2102, 32'h0000_0005, 2, 1);
      run(32'h0000_2110, 32'h0000_0009, 0, 1);
      // Back to immediate arm and scan sources before the count tests
      apb(1'b1, sat_pkg::SAT_ADDR_SRC, 32'h0000_2100);
      apb(1'b1, sat_pkg::SAT_ADDR_SCNT, 32'h0000_0003);
      apb(1'b1, sat_pkg::SAT_ADDR_DLY, 32'h0000_0002);
      b = starts;
      apb(1'b1, sat_pkg::SAT_ADDR_CTRL, 32'h0000_0001);
      repeat (8) @(posedge pclk);
      chk("delay", 33'(b), 33'(starts));
      wait_n(b + 3);
      repeat (30) @(posedge pclk);
      chk("busy", 33'h0, {32'h0, busy});
      apb(1'b1, sat_pkg::SAT_ADDR_DLY, 32'h0000_0000);
      apb(1'b1, sat_pkg::SAT_ADDR_CTRL, 32'h0000_0011);
      wait_n(b + 23);
      apb(1'b1, sat_pkg::SAT_ADDR_CTRL, 32'h0000_0002);
      repeat (5) @(posedge pclk);
      chk("abort", 33'h0, {32'h0, busy});
      apb(1'b1, sat_pkg::SAT_ADDR_SCNT, 32'h0000_0002);
      apb(1'b1, sat_pkg::SAT_ADDR_INTV, 32'h0000_0003);
      for (int i = 0; i < 2; i++)
      begin
         b = starts;
         lat <= i ? 8'h3C : 8'h02;
         apb(1'b1, sat_pkg::SAT_ADDR_SRC, 32'h0000_2105);
         apb(1'b1, sat_pkg::SAT_ADDR_CTRL, 32'h0000_0001);
         wait_n(b + 1);
         repeat (i ? 50 : 15) @(posedge pclk);
         chk("timer", 33'(b + 1), 33'(starts));
         wait_n(b + 2);
         repeat (70) @(posedge pclk);
      end
      tally_and_finish();
   end
endmodule : tb
